// [ctpc_capture.sv]
// Capacitive touch period capture: oscillator thresholds, edge capture and buffer writes
`timescale 1ns/10ps
// Notes on behaviour
// - Comparator high selects the upper threshold so the sensor charges upward.
// - Above upper threshold output goes low; below lower threshold it goes high.
// - Free-running timer value is captured at every comparator rising edge while a measurement runs.
// - N periods need N+1 rising-edge captures before the sequence is done.
// - One period is later capture minus earlier capture of adjacent edges.
// - Timer counts in 4 ns steps.
// - Measure only a few periods per pad, eight by default.
// - Each capture raises a buffer write to the next location, no processor.
// - Processor reads buffer only after completion; block flags completion.
// - Multiplexer selects any one of up to 16 pads as oscillator input.
// - Comparator frequencies from 100 kHz to 1 MHz are captured correctly.
module ctpc_capture #(
  parameter int unsigned PERIODS = ctpc_pkg::DEF_PERIODS,
  parameter int unsigned PADS = ctpc_pkg::DEF_PADS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Measurement request
  input wire ctpc_pkg::ctpc_req_type req_i,
  // Comparator inputs from analog front end (asynchronous)
  input wire logic above_upper_i,
  input wire logic below_lower_i,
  // Analog control
  output logic osc_comparator_out_o,
  output logic upper_threshold_ref_o,
  output logic lower_threshold_ref_o,
  output logic [ctpc_pkg::DEF_PADS-1:0] selected_sensor_input_o,
  // Buffer write and results
  output ctpc_pkg::ctpc_xfer_type xfer_o,
  output logic [ctpc_pkg::DEF_TIMER_W-1:0] period_o,
  output logic period_valid_o,
  output logic busy_o,
  output logic done_o
);

  localparam int unsigned TW = ctpc_pkg::DEF_TIMER_W;
  localparam int unsigned IW = ctpc_pkg::DEF_IDX_W;
  localparam int unsigned SW = ctpc_pkg::SYNC_STAGES;
  localparam logic [IW:0] LAST_CAP = (IW+1)'(PERIODS);

  // Index field must hold every capture slot 0..PERIODS
  if (PERIODS < 1 || PERIODS + 1 > (1 << IW))
  begin : g_bad_periods
    $error("ctpc_capture: unsupported PERIODS");
  end

  // Pad select is as wide as the largest pad count
  if (PADS < 1 || PADS > ctpc_pkg::DEF_PADS)
  begin : g_bad_pads
    $error("ctpc_capture: unsupported PADS");
  end

  // Wrap of the timer must exceed the longest oscillator period
  if (ctpc_pkg::OSC_MAX_PERIOD_CYC >= (1 << TW))
  begin : g_bad_timer
    $error("ctpc_capture: timer too narrow for slowest oscillator");
  end

  // Timer must advance at least one count per clock
  if (ctpc_pkg::TICKS_PER_CLK < 1)
  begin : g_bad_tick
    $error("ctpc_capture: tick longer than the clock period");
  end

  // Modulo difference of two captures
  function automatic logic [TW-1:0] ctpc_diff(input logic [TW-1:0] a, input logic [TW-1:0] b);
    ctpc_diff = a - b;
  endfunction : ctpc_diff

  // Next comparator level from the synchronised threshold crossings
  function automatic logic ctpc_hyst(input logic cur, input logic above, input logic below);
    ctpc_hyst = cur;
    if (cur && above)
    begin
      ctpc_hyst = 1'b0;
    end
    else if (!cur && below)
    begin
      ctpc_hyst = 1'b1;
    end
  endfunction : ctpc_hyst

  // Rising edge of the comparator level as seen one clock late
  function automatic logic ctpc_rise(input logic now, input logic prev);
    ctpc_rise = now && !prev;
  endfunction : ctpc_rise

  // One-hot pad select from a pad number
  function automatic logic [ctpc_pkg::DEF_PADS-1:0] ctpc_onehot(input logic [3:0] pad);
    ctpc_onehot = ctpc_pkg::DEF_PADS'(1) << pad;
  endfunction : ctpc_onehot

  // A start names a pad that this instance serves
  function automatic logic ctpc_pad_ok(input logic [3:0] pad);
    ctpc_pad_ok = 32'(pad) < PADS;
  endfunction : ctpc_pad_ok

  typedef struct packed {
    // Sequence
    ctpc_pkg::ctpc_state_type st;
    // Synchronised crossings and comparator
    logic [SW-1:0] up_s;
    logic [SW-1:0] lo_s;
    logic cmp;
    logic cmp_prev;
    // Timebase and capture bookkeeping
    logic [TW-1:0] timer;
    logic [TW-1:0] last_cap;
    logic [IW:0] n_cap;
    logic [3:0] pad;
    // Registered outputs
    ctpc_pkg::ctpc_xfer_type xfer;
    logic [TW-1:0] period;
    logic period_valid;
    logic done;
  } ctpc_regs_type;

  // Register contents while reset is asserted; no false edge after release
  localparam ctpc_regs_type RESET_VALUE = '{
    st: ctpc_pkg::CTPC_IDLE,
    cmp: 1'b1,
    cmp_prev: 1'b1,
    default: '0
  };

  // Current and next register contents
  ctpc_regs_type r_q;
  ctpc_regs_type r_d;

  always_comb
  begin
    // Synchronisers, timer and one-cycle pulses
    r_d = r_q;
    r_d.up_s = {r_q.up_s[SW-2:0], above_upper_i};
    r_d.lo_s = {r_q.lo_s[SW-2:0], below_lower_i};
    r_d.timer = r_q.timer + TW'(ctpc_pkg::TICKS_PER_CLK);
    r_d.xfer.valid = 1'b0;
    r_d.period_valid = 1'b0;
    // Relaxation oscillator hysteresis
    r_d.cmp = ctpc_hyst(r_q.cmp, r_q.up_s[SW-1], r_q.lo_s[SW-1]);
    r_d.cmp_prev = r_q.cmp;
    // Measurement sequence
    unique case (r_q.st)
      ctpc_pkg::CTPC_IDLE, ctpc_pkg::CTPC_DONE:
      begin
        // Start only for a served pad; starts while busy are ignored
        if (req_i.start && ctpc_pad_ok(req_i.pad))
        begin
          r_d.pad = req_i.pad;
          r_d.n_cap = '0;
          r_d.done = 1'b0;
          r_d.st = ctpc_pkg::CTPC_RUN;
        end
      end
      ctpc_pkg::CTPC_ARM:
      begin
        r_d.st = ctpc_pkg::CTPC_RUN;
      end
      ctpc_pkg::CTPC_RUN:
      begin
        if (ctpc_rise(r_q.cmp, r_q.cmp_prev))
        begin
          r_d.last_cap = r_q.timer;
          r_d.xfer.valid = 1'b1;
          r_d.xfer.index = r_q.n_cap[IW-1:0];
          r_d.xfer.value = r_q.timer;
          r_d.n_cap = r_q.n_cap + 1'b1;
          // First capture has no earlier edge to subtract
          if (r_q.n_cap != '0)
          begin
            r_d.period = ctpc_diff(r_q.timer, r_q.last_cap);
            r_d.period_valid = 1'b1;
          end
          // Capture slot PERIODS ends the sequence
          if (r_q.n_cap == LAST_CAP)
          begin
            r_d.st = ctpc_pkg::CTPC_DONE;
            r_d.done = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r_q <= RESET_VALUE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Analog control
  assign osc_comparator_out_o = r_q.cmp;
  assign upper_threshold_ref_o = r_q.cmp;
  assign lower_threshold_ref_o = !r_q.cmp;
  assign selected_sensor_input_o = ctpc_onehot(r_q.pad);
  // Buffer write and results
  assign xfer_o = r_q.xfer;
  assign period_o = r_q.period;
  assign period_valid_o = r_q.period_valid;
  // Sequence status
  assign busy_o = (r_q.st == ctpc_pkg::CTPC_RUN);
  assign done_o = r_q.done;

endmodule : ctpc_capture

// [ctpc_pkg.sv]
// Package for the capacitive touch period capture block
package ctpc_pkg;

  // Timer tick period and capture clock period in picoseconds
  localparam int unsigned TICK_PS = 4000;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TICKS_PER_CLK = CLK_PERIOD_PS / TICK_PS;

  // Oscillator frequency range in kHz
  localparam int unsigned OSC_MIN_KHZ = 100;
  localparam int unsigned OSC_MAX_KHZ = 1000;
  localparam int unsigned CLK_KHZ = 1000000000 / CLK_PERIOD_PS;
  // Longest oscillator period in clock cycles, rounded down
  localparam int unsigned OSC_MAX_PERIOD_CYC = CLK_KHZ / OSC_MIN_KHZ;

  // Defaults
  localparam int unsigned DEF_PERIODS = 8;
  localparam int unsigned DEF_PADS = 16;
  localparam int unsigned DEF_TIMER_W = 16;
  localparam int unsigned DEF_IDX_W = 4;
  // Flip-flops that each asynchronous crossing input passes
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CTPC_IDLE = 2'b00,
    CTPC_ARM = 2'b01,
    CTPC_RUN = 2'b10,
    CTPC_DONE = 2'b11
  } ctpc_state_type;

  // Measurement request
  typedef struct packed {
    logic start;
    logic [3:0] pad;
  } ctpc_req_type;

  // Buffer write carrying one captured timer value
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [15:0] value;
  } ctpc_xfer_type;

endpackage : ctpc_pkg

// [ctpc_capture_properties.sv]
// Port assertions for the period capture block
`timescale 1ns/10ps
module ctpc_capture_properties #(parameter int unsigned PERIODS = 8) (
  // Clock, reset and sensor crossing
  input wire logic ref_clk_i, reset_n_i, above_upper_i,
  // Oscillator and status
  input wire logic osc_comparator_out_o, upper_threshold_ref_o, lower_threshold_ref_o,
  input wire logic period_valid_o, busy_o, done_o,
  // Results
  input wire logic [15:0] selected_sensor_input_o, period_o,
  input wire ctpc_pkg::ctpc_xfer_type xfer_o
);
  logic [15:0] last_q;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i) last_q <= 16'h0000;
    else if (xfer_o.valid) last_q <= xfer_o.value;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_up; upper_threshold_ref_o == osc_comparator_out_o; endproperty
  a_up: assert property (p_up) else $error("upper ref wrong");
  property p_low; lower_threshold_ref_o == !osc_comparator_out_o; endproperty
  a_low: assert property (p_low) else $error("lower ref wrong");
  property p_fall; busy_o && above_upper_i && osc_comparator_out_o |-> ##[1:4] !osc_comparator_out_o; endproperty
  a_fall: assert property (p_fall) else $error("output did not fall");
  property p_cap; busy_o && $rose(osc_comparator_out_o) |-> ##[1:3] xfer_o.valid; endproperty
  a_cap: assert property (p_cap) else $error("edge not captured");
  property p_last; xfer_o.valid && xfer_o.index == PERIODS |-> done_o && !busy_o; endproperty
  a_last: assert property (p_last) else $error("no done at last capture");
  property p_per; xfer_o.valid && xfer_o.index != 4'h0 |-> period_valid_o && period_o == 16'(xfer_o.value - last_q); endproperty
  a_per: assert property (p_per) else $error("period wrong");
  property p_done; done_o |-> !busy_o; endproperty
  a_done: assert property (p_done) else $error("done while busy");
  property p_sel; busy_o |-> $onehot(selected_sensor_input_o); endproperty
  a_sel: assert property (p_sel) else $error("select not one-hot");
endmodule : ctpc_capture_properties
bind ctpc_capture ctpc_capture_properties #(.PERIODS(PERIODS)) ctpc_capture_properties_i (.*);

// [ctpc_osc_model.sv]
// Relaxation oscillator seen through the threshold comparators
`timescale 1ns/10ps
module ctpc_osc_model (
  // Clock, oscillator level and half period in cycles
  input wire logic ref_clk_i,
  input wire logic osc_comparator_out_o,
  input wire logic [15:0] half_i,
  // Threshold crossings
  output logic above_upper_i,
  output logic below_lower_i
);
  logic [15:0] cnt_q = 16'h0000;
  logic lvl_q = 1'b1;
  always @(posedge ref_clk_i)
  begin
    if (osc_comparator_out_o != lvl_q) cnt_q <= 16'h0000;
    else if (cnt_q < half_i) cnt_q <= cnt_q + 16'h0001;
    lvl_q <= osc_comparator_out_o;
  end
  assign above_upper_i = lvl_q && cnt_q >= half_i;
  assign below_lower_i = !lvl_q && cnt_q >= half_i;
endmodule : ctpc_osc_model

// [ctpc_capture_bench.sv]
// Self-checking bench for the period capture block
`timescale 1ns/10ps
module ctpc_capture_bench;
  localparam int unsigned PERIODS = 8;
  localparam int unsigned PADS = 12;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, osc_q = 1'b1;
  logic above_upper_i, below_lower_i, osc_comparator_out_o, upper_threshold_ref_o;
  logic lower_threshold_ref_o, period_valid_o, busy_o, done_o;
  logic [15:0] selected_sensor_input_o, period_o, half_i = 16'h0078;
  ctpc_pkg::ctpc_req_type req_i = '0;
  ctpc_pkg::ctpc_xfer_type xfer_o;
  localparam int BASE_HALF = 120;
  localparam int TOUCH = 256;
  int cyc = 0, nx = 0, checks_done = 0, miscompares = 0;
  int tn = 0, exp_sig = 0;
  logic [15:0] base = 16'h0000, sig = 16'h0000;
  int rises[$];
  logic [3:0] pad;
  ctpc_capture #(.PERIODS(PERIODS), .PADS(PADS)) ctpc_capture_i (.*);
  ctpc_osc_model ctpc_osc_model_i (.*);
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (checks_done > 0 && miscompares == 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (!osc_q && osc_comparator_out_o && busy_o) rises.push_back(cyc);
    osc_q = osc_comparator_out_o;
    if (xfer_o.valid)
    begin
      check("index", 16'(xfer_o.index), 16'(nx));
      if (nx > 0) check("period", period_o, 16'(rises[nx] - rises[nx - 1]));
      if (nx == 2 && tn == 0) base = period_o;
      sig = period_o - base;
      exp_sig = 2 * (int'(half_i) - BASE_HALF);
      if (nx >= 2) check("signal", sig, 16'(exp_sig));
      if (nx >= 2) check("touch", 16'($signed(sig) >= TOUCH), 16'(exp_sig >= TOUCH));
      nx++;
    end
    if (cyc == 100000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(39491));
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int t = 0; t < 5; t++)
    begin
      pad = 4'((t + PADS - 1) % PADS);
      half_i <= (t == 0) ? 16'(BASE_HALF) : (t == 1) ? 16'h04d8 : 16'($urandom_range(700, 120));
      @(posedge ref_clk_i);
      tn = t;
      nx = 0;
      rises.delete();
      req_i <= '{1'b1, pad};
      @(posedge ref_clk_i);
      req_i <= '{1'b1, pad ^ 4'h1};
      @(posedge ref_clk_i);
      req_i.start <= 1'b0;
      @(posedge ref_clk_i);
      check("select", selected_sensor_input_o, 16'h0001 << pad);
      while (!done_o) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      check("captures", 16'(nx), 16'(PERIODS + 1));
      $display("test %0d done on %s slider", t, (pad < PADS / 2) ? "x" : "y");
    end
    req_i <= '{1'b1, 4'hc};
    repeat (3) @(posedge ref_clk_i);
    check("busy", 16'(busy_o), 16'h0000);
    check("done", 16'(done_o), 16'h0001);
    $display("test refusal done");
    conclude();
  end
endmodule : ctpc_capture_bench
